// ==== core/wsup_defines.svh ====
`ifndef WSUP_DEFINES_SVH
`define WSUP_DEFINES_SVH

// timebase
`define CLK_PERIOD_NS       10
`define TICK_NS             100000
`define TICKS_PER_MS        10
`define CNT_W               20

// reset delay
`define RST_DELAY_MS        200
`define ALT_DELAY_MS        20
`define DLY_CODE_OPEN       2'h0

// upper window period: ticks = slope * nF + offset (0.1 ms ticks)
`define PERIOD_SLOPE_X10    774
`define PERIOD_OFFSET_TICKS 550
`define UPPER_MIN_PCT       85
`define UPPER_MAX_PCT       115
`define PCT_DIV             100

// lower bound scale, in eighths of the upper bound
`define RATIO_DIV_SHIFT     3
`define RATIO_00            4'h1
`define RATIO_01            4'h6
`define RATIO_11            4'h4
`define SEL_CODE_00         2'h0
`define SEL_CODE_01         2'h1
`define SEL_CODE_OFF        2'h2

// controller registers (byte addresses)
`define ADDR_W              5
`define REG_CTRL            5'h00
`define REG_HALF            5'h04
`define REG_STATUS          5'h08
`define REG_IRQ_STAT        5'h0c
`define REG_IRQ_MASK        5'h10

`define CTRL_AUTO_BIT       0
`define CTRL_SEL_A_BIT      1
`define CTRL_SEL_B_BIT      2
`define CTRL_TOGGLE_BIT     3
`define CTRL_RESET          4'h1
`define HALF_RESET          32'h02fa_f080

`define EV_RESET_FELL       0
`define EV_RESET_ROSE       1
`define EV_W                2

`endif

// ==== core/wsup_pkg.sv ====
package wsup_pkg;

  typedef enum logic [2:0] {
    SUP_LOW   = 3'b001,
    SUP_DELAY = 3'b010,
    SUP_OK    = 3'b100
  } supply_state_e;

  typedef enum logic [2:0] {
    WD_IDLE  = 3'b001,
    WD_RUN   = 3'b010,
    WD_FAULT = 3'b100
  } wd_state_e;

endpackage

// ==== core/wsup_if.sv ====
`timescale 1ns/1ns
interface wsup_if;
  logic watchdog_kick_input;
  logic window_select_a;
  logic window_select_b;
  logic supply_fault_o;
  logic supply_fault_oe;
  logic watchdog_fault_output_o;
  logic watchdog_fault_output_oe;
  logic reset_line;

  // one pull-up on the shared line; any enabled driver whose data is low pulls it low
  assign reset_line = !((supply_fault_oe && !supply_fault_o) ||
                        (watchdog_fault_output_oe && !watchdog_fault_output_o));

  modport device (
    input  watchdog_kick_input,
    input  window_select_a,
    input  window_select_b,
    output supply_fault_o,
    output supply_fault_oe,
    output watchdog_fault_output_o,
    output watchdog_fault_output_oe
  );

  modport host (
    output watchdog_kick_input,
    output window_select_a,
    output window_select_b,
    input  reset_line
  );
endinterface

// ==== core/supervisor_device.sv ====
`timescale 1ns/1ns
`include "wsup_defines.svh"
module supervisor_device
  import wsup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = `TICK_NS / `CLK_PERIOD_NS,
  parameter int unsigned CNT_W        = `CNT_W,
  parameter int unsigned ALT_DELAY_MS = `ALT_DELAY_MS
)(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       rail_below_threshold,
  input  wire logic       rail_above_hysteresis,
  input  wire logic [1:0] delay_program_pin,
  input  wire logic [7:0] period_program_pin,
  wsup_if.device          link
);

  localparam int unsigned SW = 15;
  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned XW = CNT_W + 8;

  function automatic logic [CNT_W-1:0] scale_pct(input logic [CNT_W-1:0] v, input logic [7:0] pct);
    logic [XW-1:0] prod;
    prod = XW'(v) * XW'(pct);
    return CNT_W'(prod / XW'(`PCT_DIV));
  endfunction

  function automatic logic [CNT_W-1:0] delay_ticks(input logic [1:0] code);
    logic [31:0] ms;
    ms = (code == `DLY_CODE_OPEN) ? 32'(`RST_DELAY_MS) : 32'(ALT_DELAY_MS);
    return CNT_W'(ms * 32'(`TICKS_PER_MS));
  endfunction

  // all pins come from outside the clock domain
  logic [SW-1:0] sync1_reg, sync1_next;
  logic [SW-1:0] sync2_reg, sync2_next;
  logic          kick_d_reg, kick_d_next;
  logic [PW-1:0] presc_reg, presc_next;
  logic          tick;

  logic       kick_s, sel_a_s, sel_b_s, below_s, above_s;
  logic [1:0] dly_code_s;
  logic [7:0] cap_nf_s;
  assign {kick_s, sel_a_s, sel_b_s, below_s, above_s, dly_code_s, cap_nf_s} = sync2_reg;

  always_comb begin
    sync1_next  = {link.watchdog_kick_input, link.window_select_a, link.window_select_b,
                   rail_below_threshold, rail_above_hysteresis, delay_program_pin, period_program_pin};
    sync2_next  = sync1_reg;
    kick_d_next = kick_s;
    tick        = (presc_reg == PW'(TICK_CYCLES - 1));
    presc_next  = tick ? '0 : presc_reg + PW'(1);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      kick_d_reg <= 1'b0;
      presc_reg  <= '0;
    end else if (ce) begin
      sync1_reg  <= sync1_next;
      sync2_reg  <= sync2_next;
      kick_d_reg <= kick_d_next;
      presc_reg  <= presc_next;
    end
  end

  // window bounds, all in 0.1 ms ticks
  logic [CNT_W-1:0] rst_delay;
  logic [CNT_W-1:0] upper_typ, upper_min, upper_max, lower_max;
  logic [3:0]       ratio;
  logic [1:0]       sel_code;
  logic             wd_enabled;
  logic [XW-1:0]    lower_prod;

  always_comb begin
    sel_code   = {sel_a_s, sel_b_s};
    wd_enabled = (sel_code != `SEL_CODE_OFF);
    rst_delay  = delay_ticks(dly_code_s);
    upper_typ  = CNT_W'(32'(`PERIOD_SLOPE_X10) * 32'(cap_nf_s) + 32'(`PERIOD_OFFSET_TICKS));
    upper_min  = scale_pct(upper_typ, 8'(`UPPER_MIN_PCT));
    upper_max  = scale_pct(upper_typ, 8'(`UPPER_MAX_PCT));
    unique case (sel_code)
      `SEL_CODE_00: ratio = `RATIO_00;
      `SEL_CODE_01: ratio = `RATIO_01;
      default:      ratio = `RATIO_11;
    endcase
    lower_prod = XW'(upper_max) * XW'(ratio);
    lower_max  = CNT_W'(lower_prod >> `RATIO_DIV_SHIFT);
  end

  // supply supervisor
  supply_state_e    sup_state_reg, sup_state_next;
  logic [CNT_W-1:0] sup_cnt_reg, sup_cnt_next;

  always_comb begin
    sup_state_next = sup_state_reg;
    sup_cnt_next   = sup_cnt_reg;
    unique case (sup_state_reg)
      SUP_LOW: begin
        sup_cnt_next = '0;
        if (!below_s && above_s) begin
          sup_state_next = SUP_DELAY;
        end
      end
      SUP_DELAY: begin
        if (below_s) begin
          sup_state_next = SUP_LOW;
        end else if (tick) begin
          if (sup_cnt_reg + CNT_W'(1) >= rst_delay) begin
            sup_state_next = SUP_OK;
          end else begin
            sup_cnt_next = sup_cnt_reg + CNT_W'(1);
          end
        end
      end
      SUP_OK: begin
        if (below_s) begin
          sup_state_next = SUP_LOW;
        end
      end
      default: sup_state_next = SUP_LOW;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sup_state_reg <= SUP_LOW;
      sup_cnt_reg   <= '0;
    end else if (ce) begin
      sup_state_reg <= sup_state_next;
      sup_cnt_reg   <= sup_cnt_next;
    end
  end

  // window watchdog
  wd_state_e        wd_state_reg, wd_state_next;
  logic [CNT_W-1:0] ivl_reg, ivl_next;
  logic             kick_fall;

  always_comb begin
    kick_fall     = kick_d_reg && !kick_s;
    wd_state_next = wd_state_reg;
    ivl_next      = ivl_reg;
    unique case (wd_state_reg)
      WD_IDLE: begin
        ivl_next = '0;
        // paused while the host is held in supply reset
        if (wd_enabled && sup_state_reg == SUP_OK) begin
          wd_state_next = WD_RUN;
        end
      end
      WD_RUN: begin
        if (!wd_enabled || sup_state_reg != SUP_OK) begin
          wd_state_next = WD_IDLE;
        end else if (kick_fall) begin
          if (ivl_reg <= lower_max) begin
            wd_state_next = WD_FAULT;
            ivl_next      = '0;
          end else begin
            ivl_next = '0;
          end
        end else if (tick) begin
          if (ivl_reg + CNT_W'(1) >= upper_min) begin
            wd_state_next = WD_FAULT;
            ivl_next      = '0;
          end else begin
            ivl_next = ivl_reg + CNT_W'(1);
          end
        end
      end
      WD_FAULT: begin
        if (!wd_enabled) begin
          wd_state_next = WD_IDLE;
        end else if (tick) begin
          if (ivl_reg + CNT_W'(1) >= rst_delay) begin
            wd_state_next = WD_RUN;
            ivl_next      = '0;
          end else begin
            ivl_next = ivl_reg + CNT_W'(1);
          end
        end
      end
      default: wd_state_next = WD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wd_state_reg <= WD_IDLE;
      ivl_reg      <= '0;
    end else if (ce) begin
      wd_state_reg <= wd_state_next;
      ivl_reg      <= ivl_next;
    end
  end

  // open-drain: data is always low, only the enable moves
  assign link.supply_fault_o           = 1'b0;
  assign link.supply_fault_oe          = (sup_state_reg != SUP_OK);
  assign link.watchdog_fault_output_o  = 1'b0;
  assign link.watchdog_fault_output_oe = (wd_state_reg == WD_FAULT);

endmodule

// ==== core/kick_controller.sv ====
`timescale 1ns/1ns
`include "wsup_defines.svh"
module kick_controller
  import wsup_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  wsup_if.host             link
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [3:0]         ctrl_reg, ctrl_next;
  logic [31:0]        half_reg, half_next;
  logic [31:0]        cnt_reg, cnt_next;
  logic               kick_reg, kick_next;
  logic [`EV_W-1:0]   stat_reg, stat_next;
  logic [`EV_W-1:0]   mask_reg, mask_next;
  logic               ack_reg, ack_next;
  logic [31:0]        rdata_reg, rdata_next;
  logic               line1_reg, line2_reg, line_d_reg;
  logic               req, wr;
  logic [31:0]        wmerge;
  logic [`EV_W-1:0]   ev;

  always_comb begin
    req        = wb_cyc_i && wb_stb_i && !ack_reg;
    wr         = req && wb_we_i;
    ctrl_next  = ctrl_reg;
    half_next  = half_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    ack_next   = req;
    rdata_next = rdata_reg;
    kick_next  = kick_reg;
    cnt_next   = cnt_reg + 32'h1;
    ev         = '0;
    ev[`EV_RESET_FELL] = line_d_reg && !line2_reg;
    ev[`EV_RESET_ROSE] = !line_d_reg && line2_reg;
    wmerge     = '0;
    unique case (wb_adr_i)
      `REG_CTRL:     wmerge = merge({28'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
      `REG_HALF:     wmerge = merge(half_reg, wb_dat_i, wb_sel_i);
      `REG_IRQ_STAT: wmerge = merge({30'h0, stat_reg}, wb_dat_i, wb_sel_i);
      `REG_IRQ_MASK: wmerge = merge({30'h0, mask_reg}, wb_dat_i, wb_sel_i);
      default:       wmerge = '0;
    endcase
    if (wr) begin
      unique case (wb_adr_i)
        `REG_CTRL: begin
          ctrl_next = wmerge[3:0] & 4'h7;
          if (wmerge[`CTRL_TOGGLE_BIT]) begin
            kick_next = !kick_reg;
            cnt_next  = '0;
          end
        end
        `REG_HALF:     half_next = wmerge;
        `REG_IRQ_STAT: stat_next = stat_reg & ~wmerge[`EV_W-1:0];
        `REG_IRQ_MASK: mask_next = wmerge[`EV_W-1:0];
        default:       ;
      endcase
    end
    // a new event beats a clear in the same cycle
    stat_next = stat_next | ev;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CTRL:     rdata_next = {28'h0, ctrl_reg};
        `REG_HALF:     rdata_next = half_reg;
        `REG_STATUS:   rdata_next = {30'h0, kick_reg, line2_reg};
        `REG_IRQ_STAT: rdata_next = {30'h0, stat_reg};
        `REG_IRQ_MASK: rdata_next = {30'h0, mask_reg};
        default:       rdata_next = '0;
      endcase
    end
    // free-running toggle; falling edges come two half periods apart
    if (ctrl_reg[`CTRL_AUTO_BIT] && cnt_reg + 32'h1 >= half_reg) begin
      kick_next = !kick_reg;
      cnt_next  = '0;
    end
    // a host held in reset restarts its kick phase from low, so the first
    // falling edge after release comes a full period later, never early
    if (!line2_reg) begin
      kick_next = 1'b0;
      cnt_next  = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg   <= `CTRL_RESET;
      half_reg   <= `HALF_RESET;
      cnt_reg    <= '0;
      kick_reg   <= 1'b0;
      stat_reg   <= '0;
      mask_reg   <= '0;
      ack_reg    <= 1'b0;
      rdata_reg  <= '0;
      line1_reg  <= 1'b1;
      line2_reg  <= 1'b1;
      line_d_reg <= 1'b1;
    end else if (ce) begin
      ctrl_reg   <= ctrl_next;
      half_reg   <= half_next;
      cnt_reg    <= cnt_next;
      kick_reg   <= kick_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      line1_reg  <= link.reset_line;
      line2_reg  <= line1_reg;
      line_d_reg <= line2_reg;
    end
  end

  assign wb_ack_o                 = ack_reg;
  assign wb_dat_o                 = rdata_reg;
  assign irq                      = |(stat_reg & mask_reg);
  assign link.watchdog_kick_input = kick_reg;
  assign link.window_select_a     = ctrl_reg[`CTRL_SEL_A_BIT];
  assign link.window_select_b     = ctrl_reg[`CTRL_SEL_B_BIT];

endmodule

// ==== verification/wsup_checker.sv ====
`timescale 1ns/1ns
module wsup_checker #(
  parameter int TC   = 4,
  parameter int DLY  = 2000,
  parameter int ALT  = 200,
  parameter int UMIN = 467
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic watchdog_kick_input,
  input wire logic window_select_a,
  input wire logic window_select_b,
  input wire logic supply_fault_o,
  input wire logic supply_fault_oe,
  input wire logic watchdog_fault_output_o,
  input wire logic watchdog_fault_output_oe
);
  localparam int PMIN = (DLY - 1) * TC;
  localparam int PMAX = DLY * TC + 1;
  localparam int SMIN = ALT * TC;
  // slack covers the kick synchroniser and tick phase
  localparam int IMAX = UMIN * TC + 2 * TC + 8;
  int         wd_cnt_reg, wd_cnt_next, sup_cnt_reg, sup_cnt_next, idle_reg, idle_next;
  logic       kick_q_reg, kick_q_next;
  logic [1:0] sel;
  assign sel = {window_select_a, window_select_b};
  always_comb begin
    kick_q_next  = watchdog_kick_input;
    wd_cnt_next  = (rst_n && watchdog_fault_output_oe) ? wd_cnt_reg + 1 : 0;
    sup_cnt_next = (rst_n && supply_fault_oe) ? sup_cnt_reg + 1 : 0;
    idle_next    = idle_reg + 1;
    if (!rst_n || watchdog_fault_output_oe || supply_fault_oe || sel == 2'b10 ||
        (kick_q_reg && !watchdog_kick_input)) begin
      idle_next = 0;
    end
  end
  always_ff @(posedge mclk) begin
    kick_q_reg  <= kick_q_next;
    wd_cnt_reg  <= wd_cnt_next;
    sup_cnt_reg <= sup_cnt_next;
    idle_reg    <= idle_next;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_holds_line: assert property (disable iff (1'b0) !rst_n |=> supply_fault_oe)
    else $error("supply reset not asserted after reset");
  a_supply_drain_only: assert property (supply_fault_o == 1'b0)
    else $error("supply fault output drives high");
  a_fault_drain_only: assert property (watchdog_fault_output_o == 1'b0)
    else $error("watchdog fault output drives high");
  a_disabled_stays_quiet: assert property ((sel == 2'b10)[*6] |-> !$rose(watchdog_fault_output_oe))
    else $error("fault while watchdog disabled");
  a_fault_pulse_len: assert property ($fell(watchdog_fault_output_oe) |-> wd_cnt_reg inside {[PMIN:PMAX]})
    else $error("fault pulse length wrong");
  a_supply_delay_min: assert property ($fell(supply_fault_oe) |-> sup_cnt_reg >= SMIN)
    else $error("supply reset released too soon");
  a_early_kick_faults: assert property (
    (sel == 2'b01 && !supply_fault_oe && !watchdog_fault_output_oe)[*4] ##0 $fell(watchdog_kick_input)
    |-> ##[1:6] watchdog_fault_output_oe) else $error("early kick not flagged");
  a_timeout_bound: assert property (idle_reg <= IMAX)
    else $error("missing kick not flagged in time");
  c_wd_fault: cover property ($rose(watchdog_fault_output_oe));
  c_supply_release: cover property ($fell(supply_fault_oe));
  c_disabled: cover property ((sel == 2'b10)[*6]);
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`include "wsup_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module testbench;
  localparam int TC = 4;
  localparam int DT = `RST_DELAY_MS * `TICKS_PER_MS;
  localparam int AT = `ALT_DELAY_MS * `TICKS_PER_MS;
  localparam int UMIN = `PERIOD_OFFSET_TICKS * `UPPER_MIN_PCT / `PCT_DIV;
  logic        mclk = 0, rst_n = 0, below = 1, above = 0, cyc = 0, stb = 0, we = 0, hi;
  logic [1:0]  dly = 0;
  logic [4:0]  adr = 0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat = 0, rd, h;
  logic [31:0] dato;
  logic        ack, irq;
  int          err_total = 0, n_checks = 0, n, i, k;
  logic [1:0]  s_tab[6] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  logic [31:0] h_tab[6];
  logic        f_tab[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  always #5 mclk = ~mclk;
  wsup_if link();
  supervisor_device #(.TICK_CYCLES(TC)) i_supervisor_device (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
    .rail_below_threshold(below), .rail_above_hysteresis(above), .delay_program_pin(dly),
    .period_program_pin(8'h00), .link(link));
  kick_controller i_kick_controller (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dato), .wb_ack_o(ack),
    .irq(irq), .link(link));
  wsup_checker #(.TC(TC), .DLY(DT), .ALT(AT), .UMIN(UMIN)) i_wsup_checker (.mclk(mclk), .rst_n(rst_n),
    .watchdog_kick_input(link.watchdog_kick_input), .window_select_a(link.window_select_a),
    .window_select_b(link.window_select_b), .supply_fault_o(link.supply_fault_o),
    .supply_fault_oe(link.supply_fault_oe), .watchdog_fault_output_o(link.watchdog_fault_output_o),
    .watchdog_fault_output_oe(link.watchdog_fault_output_oe));
  task summarize;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge mclk);
    if (i == 20) begin
      err_total++;
      summarize();
    end
    rd = dato;
    cyc <= 0;
    stb <= 0;
  endtask
  // waits until the chosen enable reaches lvl; n counts the cycles spent
  task wait_oe(input bit sup, input logic lvl, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge mclk);
      if ((sup ? link.supply_fault_oe : link.watchdog_fault_output_oe) === lvl) return;
    end
    err_total++;
    summarize();
  endtask
  initial begin
    void'($urandom(32'hf6bb));
    h = 32'd700 + $urandom_range(100);
    h_tab = '{h, h, 32'd100, h, 32'd100, 32'd500};
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    `CHK(link.supply_fault_oe, 1'b1)
    wb(1, `REG_HALF, h);
    wb(1, `REG_IRQ_MASK, 32'h2);
    wb(0, `REG_STATUS, 0);
    `CHK(rd[0], 1'b0)
    `CHK(irq, 1'b0)
    below <= 0;
    above <= 1;
    wait_oe(1, 0, DT * TC + 100, n);
    `CHK(n inside {[(DT - 1) * TC : DT * TC + TC + 8]}, 1'b1)
    repeat (10) @(posedge mclk);
    `CHK(irq, 1'b1)
    wb(1, `REG_IRQ_STAT, 32'h2);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    wb(0, 5'h14, 0);
    `CHK(rd, 32'h0)
    // rail parks between threshold and hysteresis: reset must hold
    dly <= 2'($urandom_range(3, 1));
    below <= 1;
    above <= 0;
    wait_oe(1, 1, 10, n);
    below <= 0;
    repeat (AT * TC * 2) @(posedge mclk);
    `CHK(link.supply_fault_oe, 1'b1)
    above <= 1;
    wait_oe(1, 0, AT * TC + 100, n);
    `CHK(n inside {[(AT - 1) * TC : AT * TC + TC + 8]}, 1'b1)
    dly <= 0;
    for (k = 0; k < 6; k++) begin
      // straps first: a shorter period must not meet the previous window
      wb(1, `REG_CTRL, {29'h0, s_tab[k][0], s_tab[k][1], 1'b1});
      wb(1, `REG_HALF, h_tab[k]);
      repeat (2500) @(posedge mclk);
      wait_oe(0, 0, DT * TC + 100, n);
      repeat (2000) @(posedge mclk);
      hi = 0;
      repeat (3500) begin
        @(posedge mclk);
        hi |= link.watchdog_fault_output_oe;
      end
      `CHK(hi, f_tab[k])
    end
    `CHK(link.reset_line, ~link.watchdog_fault_output_oe)
    wb(1, `REG_CTRL, 32'h0);
    wait_oe(0, 0, DT * TC + 100, n);
    wait_oe(0, 1, UMIN * TC + 100, n);
    wait_oe(0, 0, DT * TC + 100, n);
    `CHK(n inside {[(DT - 1) * TC : DT * TC + 1]}, 1'b1)
    wait_oe(0, 1, UMIN * TC + 100, n);
    `CHK(n inside {[(UMIN - 1) * TC - 1 : UMIN * TC + TC + 2]}, 1'b1)
    summarize();
  end
endmodule
